// >>> logic/ribs_pkg.sv
// Constants and types shared by the reply input buffer staging block.
// Assumes a single 40 MHz clock and an active-low asynchronous reset.
//
// Notes on behaviour
// - Sixteen-entry, seventeen-bit buffer with two pointers.
// - Reset command zeroes pointers, flags, sequencers.
// - Read-status command drives status word out.
// - Status bit zero means buffer not full.
// - Full when nine or fewer free slots.
// - Empty when read pointer equals write pointer.
// - Write sequencer idles while empty, no write.
// - Load writes four or six words, advances pointer.
// - Load-four word fills four stage-one registers.
// - Pending write finishes before next sequencer state.
// - Load-six word goes straight to payload register.
// - Move needs one full, two empty, no end.
// - Load-type tag travels with each word.
// - Tag one copies whole stage; zero copies payload.
// - Transfer sets stage-two flag, clears stage-one flag.
// - Control words held during reply; load-six touches payload.
// - Short Mode S replies drop three unused words.
// - Assembler clears stage-two flag after each word.
// - End of short reply clears both, skips location.
package ribs_pkg;

  // ==========================================================================
  // Buffer geometry and status layout
  localparam int unsigned RIBS_DATA_W     = 16;
  localparam int unsigned RIBS_ENTRY_W    = RIBS_DATA_W + 1;
  localparam int unsigned RIBS_DEPTH      = 16;
  localparam int unsigned RIBS_PTR_W      = 4;
  localparam int unsigned RIBS_TAG_BIT    = 16;
  localparam int unsigned RIBS_FULL_FREE  = 9;
  localparam logic [2:0]  RIBS_LOAD4_LEN  = 3'h4;
  localparam logic [2:0]  RIBS_LOAD6_LEN  = 3'h6;
  localparam int unsigned RIBS_STAT_W     = 16;
  localparam int unsigned RIBS_STAT_READY = 0;
  localparam int unsigned RIBS_STAT_EMPTY = 1;
  localparam int unsigned RIBS_STAT_S1    = 2;
  localparam int unsigned RIBS_STAT_S2    = 3;
  localparam logic [RIBS_PTR_W-1:0] RIBS_PTR_RESET = 4'h0;

  // ==========================================================================
  // Sequencer states
  typedef enum logic [2:0] {
    RIBS_W_IDLE,
    RIBS_W_TIME,
    RIBS_W_ANGLE,
    RIBS_W_KIND,
    RIBS_W_PAYLOAD,
    RIBS_W_WRITE
  } ribs_wseq_e;

  typedef enum logic [1:0] {
    RIBS_T_IDLE,
    RIBS_T_SKIP,
    RIBS_T_PAYLOAD,
    RIBS_T_WHOLE
  } ribs_tseq_e;

endpackage

// >>> logic/ribs_buffer_mem.sv
// Sixteen-word reply buffer storage with one write and one read port.
// Assumes pointers are kept by the instantiating module.
`timescale 1ns/1ps

module ribs_buffer_mem
  import ribs_pkg::*;
#(
  parameter int unsigned WIDTH = RIBS_ENTRY_W,
  parameter int unsigned DEPTH = RIBS_DEPTH,
  parameter int unsigned AW    = RIBS_PTR_W
)
(
  input  wire logic             clock,   // System clock.
  input  wire logic             wr_en,   // Write strobe.
  input  wire logic [AW-1:0]    wr_addr, // Write location.
  input  wire logic [WIDTH-1:0] wr_data, // Tagged word in.
  input  wire logic [AW-1:0]    rd_addr, // Read location.
  output logic      [WIDTH-1:0] rd_data  // Tagged word out.
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clock)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  assign rd_data = mem[rd_addr];

endmodule

// >>> logic/ribs_level.sv
// Fill-level decoder turning the two buffer pointers into full and empty.
// Assumes both pointers are on the same clock.
`timescale 1ns/1ps

module ribs_level
  import ribs_pkg::*;
(
  input  wire logic [RIBS_PTR_W-1:0] rd_ptr,   // Read pointer.
  input  wire logic [RIBS_PTR_W-1:0] wr_ptr,   // Write pointer.
  output logic                       is_empty, // Pointers equal.
  output logic                       is_full   // Too little room.
);

  logic [RIBS_PTR_W-1:0] used;
  logic [RIBS_PTR_W:0]   free;

  always_comb
  begin
    used     = wr_ptr - rd_ptr;
    free     = (RIBS_PTR_W+1)'(RIBS_DEPTH) - {1'b0, used};
    is_empty = (rd_ptr == wr_ptr);
    is_full  = (free <= (RIBS_PTR_W+1)'(RIBS_FULL_FREE)) && !is_empty;
  end

endmodule

// >>> logic/ribs_stage.sv
// Reply input staging: buffer writes from load commands, two hold stages,
// the write and transfer sequencers and the status word.
// Assumes command strobes are one-cycle pulses decoded on this clock.
`timescale 1ns/1ps

module ribs_stage
  import ribs_pkg::*;
(
  input  wire logic                   clock,          // 40 MHz system clock.
  input  wire logic                   rst_b,          // Async reset, low.
  input  wire logic                   cmd_reset,      // Decoded reset command.
  input  wire logic                   cmd_status,     // Decoded read-status command.
  input  wire logic                   cmd_load4,      // Decoded load-four command.
  input  wire logic                   cmd_load6,      // Decoded load-six command.
  input  wire logic                   word_valid,     // Data word present.
  input  wire logic [RIBS_DATA_W-1:0] word_data,      // Data word.
  input  wire logic                   end_of_reply,   // Assembler end flag.
  input  wire logic                   stage_two_done, // Word sent, free stage two.
  output logic [RIBS_STAT_W-1:0]      status_word,    // Status return bus.
  output logic                        status_valid,   // Status word strobe.
  output logic [RIBS_DATA_W-1:0]      out_reply_time, // Stage two reply time.
  output logic [RIBS_DATA_W-1:0]      out_power_angle,// Stage two power/angle.
  output logic [RIBS_DATA_W-1:0]      out_reply_kind, // Stage two reply type.
  output logic [RIBS_DATA_W-1:0]      out_payload,    // Stage two data word.
  output logic                        out_tag,        // Stage two load tag.
  output logic                        out_full        // Stage two full flag.
);

  // ==========================================================================
  // Pointers, storage and level
  logic [RIBS_PTR_W-1:0]   buffer_read_pointer;
  logic [RIBS_PTR_W-1:0]   buffer_write_pointer;
  logic [RIBS_ENTRY_W-1:0] rd_word;
  logic                    buf_empty;
  logic                    buf_full;
  logic [2:0]              words_left;
  logic                    load_tag;
  logic                    wr_en;
  logic                    rd_adv;

  // Words beyond the count armed by the last load command are ignored.
  assign wr_en = word_valid && (words_left != 3'h0);

  ribs_buffer_mem i_ribs_buffer_mem (
    .clock   (clock),
    .wr_en   (wr_en),
    .wr_addr (buffer_write_pointer),
    .wr_data ({load_tag, word_data}),
    .rd_addr (buffer_read_pointer),
    .rd_data (rd_word)
  );

  ribs_level i_ribs_level (
    .rd_ptr   (buffer_read_pointer),
    .wr_ptr   (buffer_write_pointer),
    .is_empty (buf_empty),
    .is_full  (buf_full)
  );

  // ==========================================================================
  // Buffer write logic
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      words_left <= 3'h0;
      load_tag   <= 1'b0;
    end
    else if (cmd_reset)
    begin
      words_left <= 3'h0;
    end
    else if (cmd_load4)
    begin
      words_left <= RIBS_LOAD4_LEN;
      load_tag   <= 1'b1;
    end
    else if (cmd_load6)
    begin
      words_left <= RIBS_LOAD6_LEN;
      load_tag   <= 1'b0;
    end
    else if (wr_en)
    begin
      words_left <= words_left - 3'h1;
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      buffer_write_pointer <= RIBS_PTR_RESET;
    end
    else if (cmd_reset)
    begin
      buffer_write_pointer <= RIBS_PTR_RESET;
    end
    else if (wr_en)
    begin
      buffer_write_pointer <= buffer_write_pointer + 4'h1;
    end
  end

  // ==========================================================================
  // Write sequencer: buffer to stage one
  ribs_wseq_e wstate;
  ribs_wseq_e next_wstate;
  logic       writing;
  logic [RIBS_DATA_W-1:0] stage_one_reply_time_reg;
  logic [RIBS_DATA_W-1:0] stage_one_power_angle_reg;
  logic [RIBS_DATA_W-1:0] stage_one_reply_kind_reg;
  logic [RIBS_DATA_W-1:0] stage_one_payload_reg;
  logic                   stage_one_tag;
  logic                   stage_one_full;
  logic                   stage_two_full;
  logic                   s1_load;
  logic                   s1_clear;
  logic                   skip_read;

  assign writing = (words_left != 3'h0) || cmd_load4 || cmd_load6;

  always_comb
  begin
    next_wstate = wstate;
    unique case (wstate)
      RIBS_W_IDLE:
      begin
        if (writing)
          next_wstate = RIBS_W_WRITE;
        else if (!buf_empty && !stage_one_full && !s1_clear)
          next_wstate = rd_word[RIBS_TAG_BIT] ? RIBS_W_TIME : RIBS_W_PAYLOAD;
        else
          next_wstate = RIBS_W_IDLE;
      end
      RIBS_W_TIME:    next_wstate = writing ? RIBS_W_TIME  : RIBS_W_ANGLE;
      RIBS_W_ANGLE:   next_wstate = writing ? RIBS_W_ANGLE : RIBS_W_KIND;
      RIBS_W_KIND:    next_wstate = writing ? RIBS_W_KIND  : RIBS_W_PAYLOAD;
      RIBS_W_PAYLOAD: next_wstate = writing ? RIBS_W_PAYLOAD : RIBS_W_IDLE;
      RIBS_W_WRITE:   next_wstate = writing ? RIBS_W_WRITE : RIBS_W_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wstate <= RIBS_W_IDLE;
    end
    else if (cmd_reset)
    begin
      wstate <= RIBS_W_IDLE;
    end
    else
    begin
      wstate <= next_wstate;
    end
  end

  // A word is consumed in a loading state only when no write is pending.
  logic s1_take;
  assign s1_take = !writing && (wstate inside {RIBS_W_TIME, RIBS_W_ANGLE, RIBS_W_KIND, RIBS_W_PAYLOAD});
  assign s1_load = s1_take && (wstate == RIBS_W_PAYLOAD);

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stage_one_reply_time_reg  <= 16'h0000;
      stage_one_power_angle_reg <= 16'h0000;
      stage_one_reply_kind_reg  <= 16'h0000;
      stage_one_payload_reg     <= 16'h0000;
      stage_one_tag             <= 1'b0;
    end
    else if (s1_take)
    begin
      unique case (wstate)
        RIBS_W_TIME:  stage_one_reply_time_reg  <= rd_word[RIBS_DATA_W-1:0];
        RIBS_W_ANGLE: stage_one_power_angle_reg <= rd_word[RIBS_DATA_W-1:0];
        RIBS_W_KIND:  stage_one_reply_kind_reg  <= rd_word[RIBS_DATA_W-1:0];
        default:
        begin
          stage_one_payload_reg <= rd_word[RIBS_DATA_W-1:0];
          stage_one_tag         <= rd_word[RIBS_TAG_BIT];
        end
      endcase
    end
  end

  // ==========================================================================
  // Transfer sequencer: stage one to stage two
  ribs_tseq_e tstate;
  ribs_tseq_e next_tstate;

  // A finished short reply is tested first, so its skip wins over a move.
  always_comb
  begin
    next_tstate = RIBS_T_IDLE;
    if (tstate == RIBS_T_IDLE)
    begin
      if (stage_one_full && stage_two_full && !stage_one_tag && !out_tag && end_of_reply)
        next_tstate = RIBS_T_SKIP;
      else if (stage_one_full && !stage_two_full && !end_of_reply)
        next_tstate = stage_one_tag ? RIBS_T_WHOLE : RIBS_T_PAYLOAD;
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tstate <= RIBS_T_IDLE;
    end
    else if (cmd_reset)
    begin
      tstate <= RIBS_T_IDLE;
    end
    else
    begin
      tstate <= next_tstate;
    end
  end

  assign s1_clear  = (tstate != RIBS_T_IDLE);
  assign skip_read = (tstate == RIBS_T_SKIP) && !buf_empty;
  assign rd_adv    = s1_take || skip_read;

  // The read pointer moves once per word taken into stage one or skipped.
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      buffer_read_pointer <= RIBS_PTR_RESET;
    end
    else if (cmd_reset)
    begin
      buffer_read_pointer <= RIBS_PTR_RESET;
    end
    else if (rd_adv)
    begin
      buffer_read_pointer <= buffer_read_pointer + 4'h1;
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stage_one_full <= 1'b0;
    end
    else if (cmd_reset)
    begin
      stage_one_full <= 1'b0;
    end
    else if (s1_load)
    begin
      stage_one_full <= 1'b1;
    end
    else if (s1_clear)
    begin
      stage_one_full <= 1'b0;
    end
  end

  // Stage two flag: a transfer setting it wins over the assembler clear.
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stage_two_full <= 1'b0;
    end
    else if (cmd_reset)
    begin
      stage_two_full <= 1'b0;
    end
    else if (tstate == RIBS_T_WHOLE || tstate == RIBS_T_PAYLOAD)
    begin
      stage_two_full <= 1'b1;
    end
    else if (tstate == RIBS_T_SKIP || stage_two_done)
    begin
      stage_two_full <= 1'b0;
    end
  end

  assign out_full = stage_two_full;

  // A reset command in a transfer cycle cancels the copy into stage two.
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      out_reply_time  <= 16'h0000;
      out_power_angle <= 16'h0000;
      out_reply_kind  <= 16'h0000;
    end
    else if (tstate == RIBS_T_WHOLE && !cmd_reset)
    begin
      out_reply_time  <= stage_one_reply_time_reg;
      out_power_angle <= stage_one_power_angle_reg;
      out_reply_kind  <= stage_one_reply_kind_reg;
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      out_payload <= 16'h0000;
      out_tag     <= 1'b0;
    end
    else if ((tstate == RIBS_T_WHOLE || tstate == RIBS_T_PAYLOAD) && !cmd_reset)
    begin
      out_payload <= stage_one_payload_reg;
      out_tag     <= stage_one_tag;
    end
  end

  // ==========================================================================
  // Status return
  // The word is captured as the command is seen and stands until the next one.
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      status_word  <= 16'h0000;
      status_valid <= 1'b0;
    end
    else
    begin
      status_valid <= cmd_status;
      if (cmd_status)
      begin
        status_word                  <= 16'h0000;
        status_word[RIBS_STAT_READY] <= !buf_full;
        status_word[RIBS_STAT_EMPTY] <= buf_empty;
        status_word[RIBS_STAT_S1]    <= stage_one_full;
        status_word[RIBS_STAT_S2]    <= stage_two_full;
      end
    end
  end

endmodule

// >>> test/ribs_stage_chk.sv
// Concurrent checks on the ports of the reply input staging block.
// Assumes one clock domain and the active-low asynchronous reset.
`timescale 1ns/1ps

module ribs_stage_chk
  import ribs_pkg::*;
(
  input wire logic                   clock,          // Clock.
  input wire logic                   rst_b,          // Reset, low.
  input wire logic                   cmd_reset,      // Reset command.
  input wire logic                   cmd_status,     // Status command.
  input wire logic                   end_of_reply,   // End flag.
  input wire logic                   stage_two_done, // Word sent.
  input wire logic [RIBS_STAT_W-1:0] status_word,    // Status bus.
  input wire logic                   status_valid,   // Status strobe.
  input wire logic [RIBS_DATA_W-1:0] out_reply_time, // Reply time.
  input wire logic [RIBS_DATA_W-1:0] out_payload,    // Data word.
  input wire logic                   out_tag,        // Load tag.
  input wire logic                   out_full        // Stage two full.
);
  // ==========================================================================
  // Properties
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  sequence s_eor_idle;
    (end_of_reply && !out_full) [*2];
  endsequence

  stat_answer_a: assert property (cmd_status |=> status_valid)
    else $error("status strobe missing after status command");
  stat_quiet_a: assert property (!cmd_status |=> !status_valid)
    else $error("status strobe without status command");
  empty_ready_a: assert property (status_valid && status_word[RIBS_STAT_EMPTY] |-> status_word[RIBS_STAT_READY])
    else $error("empty buffer reported as full");
  reset_status_a: assert property (cmd_reset ##[1:4] cmd_status |=> status_word[3:0] == 4'h3)
    else $error("status after reset command is wrong");
  reset_flag_a: assert property (cmd_reset |=> !out_full)
    else $error("stage two flag kept over reset command");
  ctrl_hold_a: assert property (!$stable(out_reply_time) |-> out_tag && out_full)
    else $error("control word changed without a load-four transfer");
  payload_move_a: assert property (!$stable(out_payload) |-> $rose(out_full))
    else $error("data word changed without setting stage two flag");
  full_hold_a: assert property (out_full && !stage_two_done && !cmd_reset && !end_of_reply |=> out_full)
    else $error("stage two flag dropped on its own");
  done_clear_a: assert property (out_full && stage_two_done |=> !out_full)
    else $error("stage two flag not cleared by word done");
  eor_stall_a: assert property (s_eor_idle |=> !out_full)
    else $error("transfer into stage two during end of reply");
endmodule

bind ribs_stage ribs_stage_chk i_ribs_stage_chk (.clock(clock), .rst_b(rst_b), .cmd_reset(cmd_reset),
  .cmd_status(cmd_status), .end_of_reply(end_of_reply), .stage_two_done(stage_two_done),
  .status_word(status_word), .status_valid(status_valid), .out_reply_time(out_reply_time),
  .out_payload(out_payload), .out_tag(out_tag), .out_full(out_full));

// >>> test/ribs_ctrl_model.sv
// Behavioural reply controller: polls status, then sends a load command and its words.
// Assumes the bench raises go for one cycle and waits for busy to fall.
`timescale 1ns/1ps

module ribs_ctrl_model
  import ribs_pkg::*;
(
  input  wire logic        clock,        // Clock.
  input  wire logic        go,           // Start a sequence.
  input  wire logic [2:0]  nwords,       // 0 poll only, 4 or 6.
  input  wire logic        slow,         // Idle cycle between words.
  input  wire logic [95:0] blk,          // Words, first lowest.
  input  wire logic [15:0] status_word,  // Status bus.
  input  wire logic        status_valid, // Status strobe.
  output logic             cmd_status,   // Status command.
  output logic             cmd_load4,    // Load-four command.
  output logic             cmd_load6,    // Load-six command.
  output logic             word_valid,   // Word strobe.
  output logic [15:0]      word_data,    // Word bus.
  output logic             busy          // Sequence running.
);
  int i;

  // ==========================================================================
  // Sequencer
  initial
  begin
    {cmd_status, cmd_load4, cmd_load6, word_valid, busy} = 5'h0;
    word_data = 16'h0;
    forever
    begin
      @(posedge clock);
      if (go)
      begin
        busy <= 1'b1;
        for (i = 0; i < 64; i++)
        begin
          cmd_status <= 1'b1;
          @(posedge clock);
          cmd_status <= 1'b0;
          @(posedge clock);
          if (status_word[RIBS_STAT_READY] || nwords == 3'h0)
            break;
        end
        // Loads only follow a status read that shows room.
        if (status_word[RIBS_STAT_READY] && nwords != 3'h0)
        begin
          cmd_load4 <= (nwords == 3'h4);
          cmd_load6 <= (nwords == 3'h6);
          @(posedge clock);
          cmd_load4 <= 1'b0;
          cmd_load6 <= 1'b0;
          for (i = 0; i < nwords; i++)
          begin
            word_valid <= 1'b1;
            word_data <= blk[16*i+:16];
            @(posedge clock);
            if (slow || i == nwords - 1)
            begin
              word_valid <= 1'b0;
              word_data <= ~blk[16*i+:16];
              if (slow)
                @(posedge clock);
            end
          end
        end
        busy <= 1'b0;
      end
    end
  end
endmodule

// >>> test/test_reply_input_buffer_staging.sv
// Self-checking bench for the reply input staging block.
// Assumes the controller model and the bound checker are compiled first.
`timescale 1ns/1ps

module test_reply_input_buffer_staging
  import ribs_pkg::*;
;
  logic        clock, rst_b, cmd_reset, end_of_reply, stage_two_done, go, slow;
  logic        cmd_status, cmd_load4, cmd_load6, word_valid, busy, status_valid, out_tag, out_full;
  logic [2:0]  nwords;
  logic [95:0] blk;
  logic [15:0] word_data, status_word, out_reply_time, out_power_angle, out_reply_kind, out_payload;
  int          failures, cmp_count, k;

  ribs_stage i_ribs_stage (.clock(clock), .rst_b(rst_b), .cmd_reset(cmd_reset), .cmd_status(cmd_status),
    .cmd_load4(cmd_load4), .cmd_load6(cmd_load6), .word_valid(word_valid), .word_data(word_data),
    .end_of_reply(end_of_reply), .stage_two_done(stage_two_done), .status_word(status_word),
    .status_valid(status_valid), .out_reply_time(out_reply_time), .out_power_angle(out_power_angle),
    .out_reply_kind(out_reply_kind), .out_payload(out_payload), .out_tag(out_tag), .out_full(out_full));

  ribs_ctrl_model i_ribs_ctrl_model (.clock(clock), .go(go), .nwords(nwords), .slow(slow), .blk(blk),
    .status_word(status_word), .status_valid(status_valid), .cmd_status(cmd_status), .cmd_load4(cmd_load4),
    .cmd_load6(cmd_load6), .word_valid(word_valid), .word_data(word_data), .busy(busy));

  // ==========================================================================
  // Tasks
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  function automatic logic [95:0] blk_of(input logic [15:0] b);
    logic [95:0] r;
    for (int i = 0; i < 6; i++)
      r[16*i+:16] = b + 16'(i);
    return r;
  endfunction

  task automatic send(input logic [2:0] n, input logic [15:0] b, input logic s);
    int t;
    nwords <= n;
    blk <= blk_of(b);
    slow <= s;
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    @(posedge clock);
    for (t = 0; busy !== 1'b0 && t < 800; t++)
      @(posedge clock);
    if (busy !== 1'b0)
    begin
      failures++;
      finish_test();
    end
  endtask

  task automatic wait_full(input logic v);
    int t;
    for (t = 0; out_full !== v && t < 200; t++)
      @(posedge clock);
    if (out_full !== v)
    begin
      failures++;
      finish_test();
    end
  endtask

  task automatic poll(input logic [3:0] exp);
    send(3'h0, 16'h0, 1'b0);
    check("status", {12'h0, status_word[3:0]}, {12'h0, exp});
  endtask

  task automatic take(input logic [15:0] t, input logic [15:0] p, input logic g);
    wait_full(1'b1);
    check("reply time", out_reply_time, t);
    check("payload", out_payload, p);
    check("tag", {15'h0, out_tag}, {15'h0, g});
    stage_two_done <= 1'b1;
    @(posedge clock);
    stage_two_done <= 1'b0;
    @(posedge clock);
  endtask

  // ==========================================================================
  // Stimulus
  initial
  begin
    clock = 1'b0;
    forever
      #12.5 clock = ~clock;
  end

  initial
  begin
    {rst_b, cmd_reset, end_of_reply, stage_two_done, go, slow} = 6'h0;
    nwords = 3'h0;
    blk = 96'h0;
    failures = 0;
    cmp_count = 0;
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    poll(4'h3);
    check("stage two full", {15'h0, out_full}, 16'h0);
    $display("test reset_state done");
    send(3'h4, 16'h1000, 1'b0);
    wait_full(1'b1);
    poll(4'hb);
    check("reply time", out_reply_time, 16'h1000);
    check("power angle", out_power_angle, 16'h1001);
    check("reply kind", out_reply_kind, 16'h1002);
    check("tag", {15'h0, out_tag}, 16'h1);
    $display("test short_block done");
    send(3'h4, 16'h2000, 1'b0);
    send(3'h6, 16'h3000, 1'b1);
    poll(4'hd);
    send(3'h4, 16'h4000, 1'b0);
    poll(4'hc);
    take(16'h1000, 16'h1003, 1'b1);
    take(16'h2000, 16'h2003, 1'b1);
    for (k = 0; k < 6; k++)
      take(16'h2000, 16'h3000 + 16'(k), 1'b0);
    take(16'h4000, 16'h4003, 1'b1);
    $display("test long_reply done");
    send(3'h4, 16'h5000, 1'b0);
    send(3'h6, 16'h6000, 1'b0);
    take(16'h5000, 16'h5003, 1'b1);
    for (k = 0; k < 3; k++)
      take(16'h5000, 16'h6000 + 16'(k), 1'b0);
    wait_full(1'b1);
    check("payload", out_payload, 16'h6003);
    end_of_reply <= 1'b1;
    wait_full(1'b0);
    poll(4'h3);
    end_of_reply <= 1'b0;
    send(3'h4, 16'h7000, 1'b0);
    take(16'h7000, 16'h7003, 1'b1);
    $display("test short_reply_skip done");
    send(3'h4, 16'h8000, 1'b0);
    send(3'h4, 16'h9000, 1'b0);
    send(3'h4, 16'ha000, 1'b0);
    cmd_reset <= 1'b1;
    @(posedge clock);
    cmd_reset <= 1'b0;
    poll(4'h3);
    check("stage two full", {15'h0, out_full}, 16'h0);
    send(3'h4, 16'hb000, 1'b0);
    take(16'hb000, 16'hb003, 1'b1);
    $display("test reset_command done");
    finish_test();
  end
endmodule
